// File: rtl/ccsl_pkg.sv
package ccsl_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COMPARE_A_VALUE = 8'h04;
    localparam logic [7:0] OFS_COMPARE_B_VALUE = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_COUNTER = 8'h10;
    localparam logic [7:0] OFS_ACTIVE_A = 8'h14;
    localparam logic [7:0] OFS_ACTIVE_B = 8'h18;

    // Control register field positions
    localparam int unsigned BIT_B_FULL = 9;
    localparam int unsigned BIT_A_FULL = 8;
    localparam int unsigned BIT_B_MODE = 6;
    localparam int unsigned BIT_A_MODE = 4;
    localparam int unsigned LSB_B_LOAD = 2;
    localparam int unsigned LSB_A_LOAD = 0;
    localparam logic [15:0] CTRL_WR_MASK = 16'h005F;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Combined compare A word: value in the upper half, fine part in byte 1
    localparam int unsigned COMPARE_A_VALUE_VALUE_LSB = 16;
    localparam int unsigned COMPARE_A_VALUE_FINE_LSB = 8;

    // Reset values and constants
    localparam logic [23:0] CMP_RESET = 24'h000000;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [3:0] STRB_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LOAD_ZERO = 2'h0,
        LOAD_PRD = 2'h1,
        LOAD_EITHER = 2'h2,
        LOAD_FREEZE = 2'h3
    } ccsl_load_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } ccsl_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } ccsl_rd_state_type;

endpackage

// File: rtl/ccsl_chan_if.sv
`timescale 1ns/10ps
interface ccsl_chan_if;
    logic wr_en;
    logic [23:0] wr_data;
    logic [23:0] wr_mask;
    logic wr_flag;
    logic imm_mode;
    logic [1:0] load_sel;
    logic at_zero;
    logic at_prd;
    logic [23:0] active;
    logic [23:0] shadow;
    logic full;

    modport ctrl (
        output wr_en, wr_data, wr_mask, wr_flag, imm_mode, load_sel, at_zero, at_prd,
        input active, shadow, full
    );
    modport chan (
        input wr_en, wr_data, wr_mask, wr_flag, imm_mode, load_sel, at_zero, at_prd,
        output active, shadow, full
    );
endinterface

// File: rtl/ccsl_shadow_chan.sv
`timescale 1ns/10ps
module ccsl_shadow_chan
    import ccsl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    ccsl_chan_if.chan ch
);

    typedef struct packed {
        logic [23:0] active;
        logic [23:0] shadow;
        logic full;
    } ccsl_chan_state_type;

    ccsl_chan_state_type st;
    ccsl_chan_state_type next_st;
    logic load_hit;

    always_comb begin
        next_st = st;
        case (ch.load_sel)
            LOAD_ZERO: load_hit = ch.at_zero;
            LOAD_PRD: load_hit = ch.at_prd;
            LOAD_EITHER: load_hit = ch.at_zero | ch.at_prd;
            default: load_hit = 1'b0; // [RULE9]
        endcase
        if (!ch.imm_mode) begin
            // Load uses the old shadow, so a same-cycle write stays pending
            if (load_hit) begin
                next_st.active = st.shadow;
                next_st.full = 1'b0; // [RULE1]
            end
            if (ch.wr_en) begin
                next_st.shadow = (st.shadow & ~ch.wr_mask) | (ch.wr_data & ch.wr_mask); // [RULE5]
                if (ch.wr_flag) begin
                    next_st.full = 1'b1; // [RULE4]
                end
            end
        end else if (ch.wr_en) begin
            // Load select ignored here
            next_st.active = (st.active & ~ch.wr_mask) | (ch.wr_data & ch.wr_mask); // [RULE10]
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{active: CMP_RESET, shadow: CMP_RESET, full: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign ch.active = st.active;
    assign ch.shadow = st.shadow;
    assign ch.full = st.full;

endmodule

// File: rtl/ccsl_time_events.sv
`timescale 1ns/10ps
module ccsl_time_events
    import ccsl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] counter_in,
    input wire logic [15:0] period_in,
    input wire logic [15:0] active_a_in,
    input wire logic [15:0] active_b_in,
    output logic at_zero_out,
    output logic at_prd_out,
    output logic eq_a_out,
    output logic eq_b_out
);

    typedef struct packed {
        logic at_zero;
        logic at_prd;
        logic eq_a;
        logic eq_b;
    } ccsl_evt_state_type;

    ccsl_evt_state_type st;
    ccsl_evt_state_type next_st;

    always_comb begin
        next_st.at_zero = (counter_in == COUNT_ZERO); // [RULE11]
        next_st.at_prd = (counter_in == period_in); // [RULE12]
        next_st.eq_a = (counter_in == active_a_in); // [RULE13]
        next_st.eq_b = (counter_in == active_b_in); // [RULE13]
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign at_zero_out = st.at_zero;
    assign at_prd_out = st.at_prd;
    assign eq_a_out = st.eq_a;
    assign eq_b_out = st.eq_b;

endmodule

// File: rtl/ccsl_compare_shadow.sv
`timescale 1ns/10ps
// Functional notes
// [RULE1] A load from shadow to active clears that channel's full flag (B at bit 9, A at bit 8).
// [RULE2] A write reaching the compare A value, 32-bit or 16-bit, sets the A full flag.
// [RULE3] A write reaching only the fine part of compare A leaves the A full flag alone.
// [RULE4] Full flag 1 means a value is pending and a new write replaces it; 0 means not full.
// [RULE5] Mode bit 0 double-buffers the channel and sends every write to the shadow.
// [RULE6] B mode bit 6 at 1 makes every B read and write reach the active register.
// [RULE7] A has its own mode bit 4 with the same shadow and immediate meanings.
// [RULE8] Load select (B bits 3-2, A bits 1-0): 00 at zero, 01 at period, 10 at either.
// [RULE9] Load select 11 freezes the active value with no loads.
// [RULE10] Load select is ignored while the channel is in immediate mode.
// [RULE11] The zero condition is the counter equal to 0x0000.
// [RULE12] The period condition is the counter equal to the period register.
// [RULE13] Each active value is compared with the counter and equality is signalled.
// [RULE14] Active and shadow share one address and the mode picks which one is reached.
// [RULE15] Reserved control bits read zero and ignore writes.
module ccsl_compare_shadow
    import ccsl_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic [15:0] TB_COUNTER_IN,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic [15:0] COMPARE_A_VALUE_OUT,
    output logic [7:0] COMPARE_A_FINE_PART_OUT,
    output logic [15:0] COMPARE_B_VALUE_OUT,
    output logic CTR_EQ_A_OUT,
    output logic CTR_EQ_B_OUT
);

    typedef struct packed {
        ccsl_wr_state_type wr_state;
        ccsl_rd_state_type rd_state;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic a_buffer_mode;
        logic b_buffer_mode;
        logic [1:0] a_load_select;
        logic [1:0] b_load_select;
        logic [15:0] time_base_period;
    } ccsl_top_state_type;

    ccsl_top_state_type st;
    ccsl_top_state_type next_st;

    ccsl_chan_if chan_a ();
    ccsl_chan_if chan_b ();

    logic at_zero;
    logic at_prd;
    logic [31:0] wmask;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic [15:0] compare_shadow_control;
    logic [23:0] a_seen;
    logic [23:0] b_seen;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    // Byte enables to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            assign wmask[8*gi +: 8] = {8{st.wstrb[gi]}};
        end
    endgenerate

    // Hold a new address or data until the previous response has gone
    assign S_AXI_AWREADY_OUT = !st.aw_got && (st.wr_state == WR_IDLE);
    assign S_AXI_WREADY_OUT = !st.w_got && (st.wr_state == WR_IDLE);
    assign S_AXI_ARREADY_OUT = (st.rd_state == RD_IDLE);
    assign aw_hs = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
    assign w_hs = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
    assign ar_hs = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    assign do_write = st.aw_got && st.w_got && (st.wr_state == WR_IDLE);

    assign S_AXI_BVALID_OUT = (st.wr_state == WR_RESP);
    assign S_AXI_BRESP_OUT = st.bresp;
    assign S_AXI_RVALID_OUT = (st.rd_state == RD_DATA);
    assign S_AXI_RDATA_OUT = st.rdata;
    assign S_AXI_RRESP_OUT = st.rresp;

    // Control word as software sees it
    always_comb begin
        compare_shadow_control = 16'h0000; // [RULE15]
        compare_shadow_control[BIT_B_FULL] = chan_b.full;
        compare_shadow_control[BIT_A_FULL] = chan_a.full;
        compare_shadow_control[BIT_B_MODE] = st.b_buffer_mode; // [RULE6]
        compare_shadow_control[BIT_A_MODE] = st.a_buffer_mode; // [RULE7]
        compare_shadow_control[LSB_B_LOAD +: 2] = st.b_load_select; // [RULE8]
        compare_shadow_control[LSB_A_LOAD +: 2] = st.a_load_select; // [RULE8]
    end

    // Shared address: mode picks shadow or active
    assign a_seen = st.a_buffer_mode ? chan_a.active : chan_a.shadow; // [RULE14]
    assign b_seen = st.b_buffer_mode ? chan_b.active : chan_b.shadow; // [RULE14]

    // Read decode
    always_comb begin
        rd_word = RDATA_RESET;
        rd_hit = 1'b1;
        case (S_AXI_ARADDR_IN)
            OFS_CTRL: rd_word[15:0] = compare_shadow_control;
            OFS_COMPARE_A_VALUE: rd_word[31:COMPARE_A_VALUE_FINE_LSB] = a_seen;
            OFS_COMPARE_B_VALUE: rd_word[15:0] = b_seen[23:8];
            OFS_PERIOD: rd_word[15:0] = st.time_base_period;
            OFS_COUNTER: rd_word[15:0] = TB_COUNTER_IN;
            OFS_ACTIVE_A: rd_word[31:COMPARE_A_VALUE_FINE_LSB] = chan_a.active;
            OFS_ACTIVE_B: rd_word[15:0] = chan_b.active[23:8];
            default: rd_hit = 1'b0;
        endcase
    end

    // Write decode target check
    always_comb begin
        case (st.awaddr)
            OFS_CTRL: wr_hit = 1'b1;
            OFS_COMPARE_A_VALUE: wr_hit = 1'b1;
            OFS_COMPARE_B_VALUE: wr_hit = 1'b1;
            OFS_PERIOD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Channel write strobes; B value is kept in the upper 16 of 24 bits
    always_comb begin
        chan_a.wr_en = do_write && (st.awaddr == OFS_COMPARE_A_VALUE) && (st.wstrb[3:1] != 3'h0);
        chan_a.wr_data = st.wdata[31:COMPARE_A_VALUE_FINE_LSB];
        chan_a.wr_mask = wmask[31:COMPARE_A_VALUE_FINE_LSB];
        // Fine-only write leaves the flag
        chan_a.wr_flag = (st.wstrb[3:2] != 2'h0); // [RULE2] [RULE3]
        chan_a.imm_mode = st.a_buffer_mode; // [RULE7]
        chan_a.load_sel = st.a_load_select;
        chan_a.at_zero = at_zero;
        chan_a.at_prd = at_prd;

        chan_b.wr_en = do_write && (st.awaddr == OFS_COMPARE_B_VALUE) && (st.wstrb[1:0] != 2'h0);
        chan_b.wr_data = {st.wdata[15:0], 8'h00};
        chan_b.wr_mask = {wmask[15:0], 8'h00};
        chan_b.wr_flag = 1'b1;
        chan_b.imm_mode = st.b_buffer_mode; // [RULE6]
        chan_b.load_sel = st.b_load_select;
        chan_b.at_zero = at_zero;
        chan_b.at_prd = at_prd;
    end

    // Bus and configuration state
    always_comb begin
        next_st = st;
        if (aw_hs) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = {S_AXI_AWADDR_IN[7:2], 2'b00};
        end
        if (w_hs) begin
            next_st.w_got = 1'b1;
            next_st.wdata = S_AXI_WDATA_IN;
            next_st.wstrb = S_AXI_WSTRB_IN;
        end
        case (st.wr_state)
            WR_IDLE: begin
                if (do_write) begin
                    next_st.aw_got = 1'b0;
                    next_st.w_got = 1'b0;
                    next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
                    next_st.wr_state = WR_RESP;
                    if ((st.awaddr == OFS_CTRL) && st.wstrb[0]) begin
                        // Only writable bits land
                        next_st.b_buffer_mode = st.wdata[BIT_B_MODE] & CTRL_WR_MASK[BIT_B_MODE]; // [RULE15]
                        next_st.a_buffer_mode = st.wdata[BIT_A_MODE] & CTRL_WR_MASK[BIT_A_MODE];
                        next_st.b_load_select = st.wdata[LSB_B_LOAD +: 2];
                        next_st.a_load_select = st.wdata[LSB_A_LOAD +: 2];
                    end
                    if (st.awaddr == OFS_PERIOD) begin
                        next_st.time_base_period = (st.time_base_period & ~wmask[15:0])
                            | (st.wdata[15:0] & wmask[15:0]);
                    end
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY_IN) begin
                    next_st.wr_state = WR_IDLE;
                end
            end
            default: next_st.wr_state = WR_IDLE;
        endcase
        case (st.rd_state)
            RD_IDLE: begin
                if (ar_hs) begin
                    next_st.rdata = rd_word;
                    next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
                    next_st.rd_state = RD_DATA;
                end
            end
            RD_DATA: begin
                if (S_AXI_RREADY_IN) begin
                    next_st.rd_state = RD_IDLE;
                end
            end
            default: next_st.rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st <= '{
                wr_state: WR_IDLE,
                rd_state: RD_IDLE,
                aw_got: 1'b0,
                w_got: 1'b0,
                awaddr: ADDR_RESET,
                wdata: RDATA_RESET,
                wstrb: STRB_RESET,
                bresp: RESP_OKAY,
                rdata: RDATA_RESET,
                rresp: RESP_OKAY,
                a_buffer_mode: CTRL_RESET[BIT_A_MODE],
                b_buffer_mode: CTRL_RESET[BIT_B_MODE],
                a_load_select: CTRL_RESET[LSB_A_LOAD +: 2],
                b_load_select: CTRL_RESET[LSB_B_LOAD +: 2],
                time_base_period: PERIOD_RESET
            };
        end else begin
            st <= next_st;
        end
    end

    ccsl_shadow_chan u_chan_a (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .ch(chan_a.chan)
    );

    ccsl_shadow_chan u_chan_b (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .ch(chan_b.chan)
    );

    // Events registered one cycle, so loads trail the counter match by one
    ccsl_time_events u_events (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .counter_in(TB_COUNTER_IN),
        .period_in(st.time_base_period),
        .active_a_in(chan_a.active[23:8]),
        .active_b_in(chan_b.active[23:8]),
        .at_zero_out(at_zero),
        .at_prd_out(at_prd),
        .eq_a_out(CTR_EQ_A_OUT),
        .eq_b_out(CTR_EQ_B_OUT)
    );

    assign COMPARE_A_VALUE_OUT = chan_a.active[23:8];
    assign COMPARE_A_FINE_PART_OUT = chan_a.active[7:0];
    assign COMPARE_B_VALUE_OUT = chan_b.active[23:8];

endmodule

// File: tb/ccsl_compare_shadow_chk.sv
`timescale 1ns/10ps
module ccsl_compare_shadow_chk
    import ccsl_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic [15:0] TB_COUNTER_IN,
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WVALID_IN,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic [1:0] S_AXI_RRESP_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic [15:0] COMPARE_A_VALUE_OUT,
    input wire logic [15:0] COMPARE_B_VALUE_OUT,
    input wire logic CTR_EQ_A_OUT,
    input wire logic CTR_EQ_B_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_B_IN);

    a_eq_a_match: assert property ((TB_COUNTER_IN == COMPARE_A_VALUE_OUT) |=> CTR_EQ_A_OUT)
        else $error("compare A equality not flagged");
    a_eq_b_miss: assert property ((TB_COUNTER_IN != COMPARE_B_VALUE_OUT) |=> !CTR_EQ_B_OUT)
        else $error("compare B equality flagged without a match");
    a_ctrl_reserved_zero: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == OFS_CTRL
        |=> S_AXI_RVALID_OUT && (S_AXI_RDATA_OUT & 32'hFFFFFCA0) == 32'h00000000)
        else $error("reserved control bits read nonzero");
    a_unmapped_read: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == 8'h1C
        |=> S_AXI_RRESP_OUT == RESP_SLVERR && S_AXI_RDATA_OUT == 32'h00000000)
        else $error("unmapped read not refused");
    a_read_latency: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read data late");
    a_write_latency: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT
        |-> ##[1:2] S_AXI_BVALID_OUT)
        else $error("write response late");
    a_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
        else $error("write response dropped early");
    a_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("read data dropped early");
    a_write_block: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
        else $error("write taken while response pending");
    a_read_block: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
        else $error("read taken while data pending");

    c_active_a_change: cover property (!$stable(COMPARE_A_VALUE_OUT));
    c_write_refused: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR);
    c_eq_b_seen: cover property (CTR_EQ_B_OUT);
endmodule

bind ccsl_compare_shadow ccsl_compare_shadow_chk ccsl_compare_shadow_chk_inst (
    .CLK_SYS_IN, .RST_B_IN, .TB_COUNTER_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN,
    .S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN,
    .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT,
    .S_AXI_RREADY_IN, .COMPARE_A_VALUE_OUT, .COMPARE_B_VALUE_OUT, .CTR_EQ_A_OUT, .CTR_EQ_B_OUT
);

// File: tb/ccsl_compare_shadow_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module ccsl_compare_shadow_tb
    import ccsl_pkg::*;
;
    localparam logic [15:0] IDLE_CNT = 16'h5A5A;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] cnt = IDLE_CNT;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, act_fine;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, eq_a, eq_b;
    logic [1:0] bresp, rresp;
    logic [15:0] act_a, act_b;
    // Behavioural copy of the registers
    logic [23:0] sh_a = 24'h000000, ac_a = 24'h000000;
    logic [15:0] sh_b = 16'h0000, ac_b = 16'h0000, prd = 16'h0000;
    logic fa = 1'b0, fb = 1'b0, ma = 1'b0, mb = 1'b0;
    logic [1:0] la = 2'h0, lb = 2'h0;
    integer seed = 32'hbd17;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #25 clk = ~clk;

    ccsl_compare_shadow ccsl_compare_shadow_inst (
        .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .TB_COUNTER_IN(cnt),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .COMPARE_A_VALUE_OUT(act_a), .COMPARE_A_FINE_PART_OUT(act_fine), .COMPARE_B_VALUE_OUT(act_b),
        .CTR_EQ_A_OUT(eq_a), .CTR_EQ_B_OUT(eq_b)
    );

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Ready held back on purpose so the slave must keep its answer standing
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s, input logic [1:0] er);
        bit aw_done = 1'b0;
        bit w_done = 1'b0;
        awaddr <= a;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        repeat (2) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        dv = rdata;
        rv = rresp;
    endtask

    task automatic set_ctrl(input logic [31:0] dv);
        axi_wr(OFS_CTRL, dv, 4'hF, RESP_OKAY);
        la = dv[1:0];
        lb = dv[3:2];
        ma = dv[4];
        mb = dv[6];
    endtask

    task automatic wr_a(input logic [31:0] dv, input logic [3:0] s);
        logic [23:0] t;
        t = ma ? ac_a : sh_a;
        if (s[1]) t[7:0] = dv[15:8];
        if (s[2]) t[15:8] = dv[23:16];
        if (s[3]) t[23:16] = dv[31:24];
        if (ma) ac_a = t;
        else sh_a = t;
        if (!ma && (s[3] || s[2])) fa = 1'b1;
        axi_wr(OFS_COMPARE_A_VALUE, dv, s, RESP_OKAY);
    endtask

    task automatic wr_b(input logic [31:0] dv, input logic [3:0] s);
        logic [15:0] t;
        t = mb ? ac_b : sh_b;
        if (s[0]) t[7:0] = dv[7:0];
        if (s[1]) t[15:8] = dv[15:8];
        if (mb) ac_b = t;
        else sh_b = t;
        if (!mb && (s[1] || s[0])) fb = 1'b1;
        axi_wr(OFS_COMPARE_B_VALUE, dv, s, RESP_OKAY);
    endtask

    function automatic bit hit(input logic [1:0] sel, input logic [15:0] v);
        return (sel == 2'h0 && v == 16'h0000) || (sel == 2'h1 && v == prd) || (sel == 2'h2 && (v == 16'h0000 || v == prd));
    endfunction

    // One counter sample, then idle long enough for the load to land
    task automatic pulse(input logic [15:0] v);
        cnt <= v;
        @(posedge clk);
        cnt <= IDLE_CNT;
        repeat (4) @(posedge clk);
        if (!ma && hit(la, v)) begin
            ac_a = sh_a;
            fa = 1'b0;
        end
        if (!mb && hit(lb, v)) begin
            ac_b = sh_b;
            fb = 1'b0;
        end
    endtask

    task automatic chk_all();
        axi_rd(OFS_CTRL, d, r);
        `CHK(d, {22'h000000, fb, fa, 1'b0, mb, 1'b0, ma, lb, la})
        axi_rd(OFS_COMPARE_A_VALUE, d, r);
        `CHK(d, {ma ? ac_a : sh_a, 8'h00})
        axi_rd(OFS_COMPARE_B_VALUE, d, r);
        `CHK(d, {16'h0000, mb ? ac_b : sh_b})
        `CHK({act_a, act_fine, act_b}, {ac_a, ac_b})
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk_all();
        axi_rd(8'h1C, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h00000000})
        axi_wr(OFS_COUNTER, 32'h0000FFFF, 4'hF, RESP_SLVERR);
        prd = {1'b1, 15'($random(seed))};
        axi_wr(OFS_PERIOD, {16'h0000, prd}, 4'h3, RESP_OKAY);
        for (int l = 0; l < 4; l++) begin
            set_ctrl(32'hFFFFFFA0 | 32'(l * 5));
            wr_a($random(seed), l[0] ? 4'hF : 4'hC);
            wr_b($random(seed), 4'h3);
            chk_all();
            wr_a($random(seed), 4'hC);
            pulse(COUNT_ZERO);
            wr_a($random(seed), 4'h2);
            chk_all();
            pulse(prd);
            chk_all();
        end
        set_ctrl(32'h0000005A);
        wr_a($random(seed), 4'hF);
        wr_b($random(seed), 4'h3);
        chk_all();
        pulse(COUNT_ZERO);
        pulse(prd);
        chk_all();
        cnt <= ac_b;
        repeat (2) @(posedge clk);
        `CHK({eq_b, eq_a}, {1'b1, ac_a[23:8] == ac_b})
        cnt <= IDLE_CNT;
        wrap_up();
    end
endmodule
